// file: common/caps_pkg.sv
// register map, field layout and fixed values of the capability bank
package caps_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] MEMORY_SIZE_CAPS_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] CORE_FEATURE_CAPS_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] PERIPHERAL_PRESENCE_CAPS_OFS = 12'h014;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------
  // memory size word
  // ----------------------------------------
  localparam logic [15:0] SRAM_SIZE_CODE = 16'h000F;
  localparam logic [15:0] FLASH_SIZE_CODE = 16'h0007;

  // ----------------------------------------
  // core feature word bit positions
  // ----------------------------------------
  localparam int PWM_PRESENT_BIT = 20;
  localparam int MIN_SYSTEM_CLOCK_DIVISOR_LSB = 12;
  localparam logic [3:0] MIN_SYSTEM_DIVISOR = 4'h7;
  localparam int MEMORY_PROTECTION_BIT = 7;
  localparam int PLL_PRESENT_BIT = 4;
  localparam int WATCHDOG_BIT = 3;
  localparam int TRACE_OUTPUT_BIT = 2;
  localparam int SERIAL_DEBUG_BIT = 1;
  localparam int JTAG_BIT = 0;

  // ----------------------------------------
  // peripheral presence word bit positions
  // ----------------------------------------
  localparam int COMPARATOR_0_BIT = 24;
  localparam int GP_TIMER_0_BIT = 16;
  localparam int SYNC_SERIAL_BIT = 4;
  localparam int SERIAL_PORT_0_BIT = 0;
  localparam int NUM_COMPARATORS = 3;
  localparam int NUM_GP_TIMERS = 3;
  localparam int NUM_SERIAL_PORTS = 2;
endpackage

// file: test/caps_regs_sva.sv
// checker of the capability register bank ports
`timescale 1ns/100ps
module caps_regs_sva (
  // request
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // answer
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] clock_gating_mask
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel & hready & htrans[1];
  wire rd = take & !hwrite;
  mem_word_a: assert property (
    rd && haddr[11:0] == 12'h008 |=> hrdata == 32'h000F0007) else $error("memory word");
  core_word_a: assert property (
    rd && haddr[11:0] == 12'h010 |=> hrdata == 32'h0010709F) else $error("core word");
  periph_word_a: assert property (
    rd && haddr[11:0] == 12'h014 |=> hrdata == 32'h07070013) else $error("periph word");
  unmapped_read_a: assert property (
    rd && haddr[11:0] == 12'h00C |=> hrdata == 32'h0) else $error("unmapped read");
  write_ignored_a: assert property (
    take && hwrite |=> hrdata == 32'h0) else $error("write answer");
  idle_hold_a: assert property (
    !take |=> $stable(hrdata)) else $error("read data moved");
  okay_resp_a: assert property (
    hreadyout && !hresp) else $error("not ready or not okay");
  gating_mask_a: assert property (
    $past(hresetn) |-> clock_gating_mask == 32'h0010000F) else $error("gating mask");
  cover property (rd);
  cover property (take && hwrite);
  cover property (rd && haddr[11:0] == 12'h00C);
endmodule

// file: test/device_capability_registers_tb_top.sv
// self-checking bench of the capability register bank
`timescale 1ns/100ps
module device_capability_registers_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, mask, r;
  logic hreadyout, hresp;
  int miscompares = 0;
  int checked = 0;
  logic [11:0] ofs [5] = '{12'h008, 12'h010, 12'h014, 12'h00C, 12'h018};
  logic [31:0] val [5] = '{32'h000F0007, 32'h0010709F, 32'h07070013, 32'h0, 32'h0};
  always #20 hclk = ~hclk;
  device_capability_registers device_capability_registers_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .clock_gating_mask(mask));
  task cmp(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // single transfer; the master waits on hready, never on a fixed count
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task read_all;
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, ofs[i], 32'h0);
      cmp("hrdata", val[i], r);
    end
  endtask
  task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40 * 2000);
    miscompares++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1 cmp("mask", 32'h0010000F, mask);
    read_all;
    $display("test reads done");
    for (int i = 0; i < 5; i++) xfer(1'b1, ofs[i], 32'hFFFFFFFF);
    read_all;
    $display("test writes done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    read_all;
    $display("test reset done");
    conclude;
  end
endmodule
bind device_capability_registers caps_regs_sva caps_regs_sva_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clock_gating_mask(clock_gating_mask));

// file: verilog/device_capability_registers.sv
// read-only capability register bank on an ahb-lite slave port
`timescale 1ns/100ps
module device_capability_registers #(
  parameter int NUM_COMPARATORS = caps_pkg::NUM_COMPARATORS,
  parameter int NUM_GP_TIMERS = caps_pkg::NUM_GP_TIMERS,
  parameter int NUM_SERIAL_PORTS = caps_pkg::NUM_SERIAL_PORTS
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // mask toward the clock-gating control registers
  output logic [31:0] clock_gating_mask
);

  // ----------------------------------------
  // fixed capability words
  // ----------------------------------------
  function automatic logic [31:0] core_feature_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[caps_pkg::PWM_PRESENT_BIT] = 1'b1;
    w[caps_pkg::MIN_SYSTEM_CLOCK_DIVISOR_LSB +: 4] = caps_pkg::MIN_SYSTEM_DIVISOR;
    w[caps_pkg::MEMORY_PROTECTION_BIT] = 1'b1;
    w[caps_pkg::PLL_PRESENT_BIT] = 1'b1;
    w[caps_pkg::WATCHDOG_BIT] = 1'b1;
    w[caps_pkg::TRACE_OUTPUT_BIT] = 1'b1;
    w[caps_pkg::SERIAL_DEBUG_BIT] = 1'b1;
    w[caps_pkg::JTAG_BIT] = 1'b1;
    return w;
  endfunction

  function automatic logic [31:0] peripheral_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < NUM_COMPARATORS; i++) begin
      w[caps_pkg::COMPARATOR_0_BIT + i] = 1'b1;
    end
    for (int i = 0; i < NUM_GP_TIMERS; i++) begin
      w[caps_pkg::GP_TIMER_0_BIT + i] = 1'b1;
    end
    w[caps_pkg::SYNC_SERIAL_BIT] = 1'b1;
    for (int i = 0; i < NUM_SERIAL_PORTS; i++) begin
      w[caps_pkg::SERIAL_PORT_0_BIT + i] = 1'b1;
    end
    return w;
  endfunction

  // only the masking presence bits survive, everything else goes as zero
  function automatic logic [31:0] gating_mask_of(input logic [31:0] cf);
    logic [31:0] m;
    m = 32'h0000_0000;
    m[caps_pkg::PWM_PRESENT_BIT] = cf[caps_pkg::PWM_PRESENT_BIT];
    m[caps_pkg::WATCHDOG_BIT] = cf[caps_pkg::WATCHDOG_BIT];
    m[caps_pkg::TRACE_OUTPUT_BIT] = cf[caps_pkg::TRACE_OUTPUT_BIT];
    m[caps_pkg::SERIAL_DEBUG_BIT] = cf[caps_pkg::SERIAL_DEBUG_BIT];
    m[caps_pkg::JTAG_BIT] = cf[caps_pkg::JTAG_BIT];
    return m;
  endfunction

  localparam logic [31:0] MEMORY_SIZE_WORD =
    {caps_pkg::SRAM_SIZE_CODE, caps_pkg::FLASH_SIZE_CODE};

  // ----------------------------------------
  // address phase
  // ----------------------------------------
  logic access_valid;
  logic [31:0] nxt_rdata;
  assign access_valid = hsel && hready &&
    (htrans == caps_pkg::HTRANS_NONSEQ || htrans == caps_pkg::HTRANS_SEQ);

  // reads are decoded in the address phase so data stands in the data phase;
  // unmapped offsets and reserved bits read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (haddr[caps_pkg::ADDR_W-1:0])
      caps_pkg::MEMORY_SIZE_CAPS_OFS: nxt_rdata = MEMORY_SIZE_WORD;
      caps_pkg::CORE_FEATURE_CAPS_OFS: nxt_rdata = core_feature_word();
      caps_pkg::PERIPHERAL_PRESENCE_CAPS_OFS: nxt_rdata = peripheral_word();
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // data phase: zero wait states, always okay
  // ----------------------------------------
  // writes are accepted and dropped; the bank holds no writable state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (access_valid && !hwrite) begin
      hrdata <= nxt_rdata;
    end else if (access_valid) begin
      hrdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------
  // clock-gating mask
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_gating_mask <= 32'h0000_0000;
    end else begin
      clock_gating_mask <= gating_mask_of(core_feature_word());
    end
  end

endmodule
